// ==== smc_mode_ctrl.sv ====
// operating-mode controller: modes, strap sampling, reset output, watchdog
// assumes a 200 MHz core_clk, avalon-mm master, asynchronous pins
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYC = `SMC_RESET_DELAY_CYC,
  parameter int unsigned LONG_WINDOW_CYC = `SMC_LONG_WINDOW_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic main_supply_ok,
  input wire logic supply_uv_timeout_ok,
  input wire logic thermal_shutdown_level_two,
  input wire logic main_supply_short,
  input wire logic wake_event,
  input wire logic strap_in,
  output logic strap_out,
  output logic strap_oe,
  output logic strap_pullup_en,
  output logic fail_outputs,
  output logic reset_output_pin_n,
  output logic main_regulator_en,
  output logic main_supply_undervoltage_flag,
  output smc_pkg::smc_mode_t operating_mode
);
  import smc_pkg::*;
  // ==========================================================
  // synchronised pins
  logic supply_ok_s;
  logic uv_to_ok_s;
  logic tsd_s;
  logic short_s;
  logic wake_s;
  logic strap_s;
  smc_sync #(.RST_VAL(1'b0)) u_sync_sup (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(main_supply_ok), .pin_sync(supply_ok_s));
  smc_sync #(.RST_VAL(1'b0)) u_sync_uvto (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(supply_uv_timeout_ok),
    .pin_sync(uv_to_ok_s));
  smc_sync #(.RST_VAL(1'b0)) u_sync_tsd (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(thermal_shutdown_level_two),
    .pin_sync(tsd_s));
  smc_sync #(.RST_VAL(1'b0)) u_sync_sc (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(main_supply_short), .pin_sync(short_s));
  smc_sync #(.RST_VAL(1'b0)) u_sync_wk (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(wake_event), .pin_sync(wake_s));
  smc_sync #(.RST_VAL(1'b1)) u_sync_st (.core_clk(core_clk),
    .sys_rst(sys_rst), .pin_in(strap_in), .pin_sync(strap_s));
  // ==========================================================
  // state
  smc_mode_t mode_reg;
  smc_mode_t mode_next;
  logic [2:0] mode_field_reg;
  logic [2:0] mode_field_next;
  logic miss_sel_reg;
  logic miss_sel_next;
  logic limit_reg;
  logic limit_next;
  logic debug_reg;
  logic debug_next;
  logic released_reg;
  logic released_next;
  logic miss_cnt_reg;
  logic miss_cnt_next;
  logic [1:0] rst_cnt_reg;
  logic [1:0] rst_cnt_next;
  logic fail_reg;
  logic fail_next;
  logic wd_fail_reg;
  logic wd_fail_next;
  logic uv_reg;
  logic uv_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // ==========================================================
  // bus decode
  logic req;
  logic wr_now;
  logic wr_mode;
  logic wr_hw;
  logic wr_wd;
  logic trig;
  logic any_cmd;
  assign req = (avs_read || avs_write) && !ack_reg;
  assign wr_now = avs_write && !ack_reg;
  assign any_cmd = req;
  assign wr_mode = wr_now && avs_address == `SMC_MODE_CTRL_OFS
    && avs_byteenable[0];
  assign wr_hw = wr_now && avs_address == `SMC_HARDWARE_CONTROL_REGISTER_OFS
    && avs_byteenable[0];
  assign wr_wd = wr_now && avs_address == `SMC_WATCHDOG_CONTROL_REGISTER_OFS
    && avs_byteenable[0];
  assign trig = wr_wd && avs_writedata[`SMC_WD_TRIG_BIT];
  // ==========================================================
  // timers
  logic rd_start;
  logic rd_run;
  logic rd_done;
  logic wd_start;
  logic wd_run;
  logic wd_done;
  logic wd_stop;
  logic in_restart;
  logic critical;
  assign critical = tsd_s || short_s;
  assign in_restart = mode_reg == SMC_RESTART;
  // reset delay reloads while the supply is low or restart is entered
  assign rd_start = !supply_ok_s
    || (mode_reg != SMC_RESTART && mode_next == SMC_RESTART)
    || (mode_reg == SMC_INIT && !released_reg && !rd_run
        && !rd_done && supply_ok_s);
  smc_timer #(.WIDTH(32), .COUNT(RESET_DELAY_CYC)) u_rd (
    .core_clk(core_clk), .sys_rst(sys_rst), .start(rd_start),
    .stop(1'b0), .hold(1'b0), .running(rd_run),
    .expired(rd_done));
  // window reloads after each expiry so a second miss can be counted
  assign wd_start = (rd_done && mode_reg == SMC_INIT) || trig
    || (rd_done && in_restart) || wd_done;
  assign wd_stop = mode_reg == SMC_SLEEP || mode_reg == SMC_FAILSAFE
    || mode_reg == SMC_RESTART || !released_reg;
  smc_timer #(.WIDTH(32), .COUNT(LONG_WINDOW_CYC)) u_wd (
    .core_clk(core_clk), .sys_rst(sys_rst), .start(wd_start),
    .stop(wd_stop), .hold(debug_reg), .running(wd_run),
    .expired(wd_done));
  // ==========================================================
  // mode and control next values
  logic miss_fires;
  always_comb begin
    mode_next = mode_reg;
    mode_field_next = mode_field_reg;
    miss_sel_next = miss_sel_reg;
    limit_next = limit_reg;
    debug_next = debug_reg;
    released_next = released_reg;
    miss_cnt_next = miss_cnt_reg;
    rst_cnt_next = rst_cnt_reg;
    fail_next = fail_reg;
    wd_fail_next = wd_fail_reg;
    uv_next = uv_reg;
    miss_fires = 1'b0;
    if (wr_hw) begin
      miss_sel_next = avs_writedata[`SMC_HW_MISS_SEL_BIT];
    end
    if (wr_wd) begin
      limit_next = avs_writedata[`SMC_WD_LIMIT_BIT];
    end
    if (mode_reg == SMC_INIT && !released_reg) begin
      debug_next = !strap_s;
    end
    if (trig) begin
      miss_cnt_next = 1'b0;
    end
    // undervoltage flag only once a threshold has been passed
    if (!supply_ok_s && (released_reg || uv_to_ok_s)) begin
      uv_next = 1'b1;
    end else if (wr_mode && avs_writedata[3]) begin
      uv_next = 1'b0;
    end
    if (wd_done && !debug_reg) begin
      if (miss_sel_reg || miss_cnt_reg) begin
        miss_fires = 1'b1;
        miss_cnt_next = 1'b0;
      end else begin
        miss_cnt_next = 1'b1;
      end
    end
    if (miss_fires) begin
      wd_fail_next = 1'b1;
      fail_next = 1'b1;
    end
    case (mode_reg)
      SMC_INIT: begin
        if (rd_done) begin
          released_next = 1'b1;
        end
        if (released_reg && any_cmd) begin
          mode_next = SMC_NORMAL;
          mode_field_next = SMC_NORMAL;
        end
        if (miss_fires) begin
          mode_next = SMC_RESTART;
        end
        // wake_s is not looked at in init
      end
      SMC_NORMAL, SMC_STOP: begin
        if (wr_mode) begin
          case (avs_writedata[2:0])
            SMC_NORMAL: mode_next = SMC_NORMAL;
            SMC_STOP: mode_next = SMC_STOP;
            SMC_SLEEP: mode_next = (mode_reg == SMC_STOP) ?
              SMC_RESTART : SMC_SLEEP;
            `SMC_MODE_SOFT_RST: mode_next = SMC_INIT;
            default: mode_next = mode_reg;
          endcase
          mode_field_next = avs_writedata[2:0];
          if (avs_writedata[2:0] == `SMC_MODE_SOFT_RST) begin
            released_next = 1'b0;
            mode_field_next = SMC_INIT;
          end
        end
        if (miss_fires) begin
          if (limit_reg && rst_cnt_reg == `SMC_RESET_LIMIT) begin
            mode_next = mode_reg;
          end else begin
            mode_next = SMC_RESTART;
            if (rst_cnt_reg != `SMC_RESET_LIMIT) begin
              rst_cnt_next = rst_cnt_reg + 2'h1;
            end
          end
        end
        if (trig) begin
          rst_cnt_next = 2'h0;
        end
        if (!supply_ok_s) begin
          mode_next = SMC_RESTART;
        end
      end
      SMC_SLEEP: begin
        if (wake_s) begin
          mode_next = SMC_RESTART;
        end
      end
      SMC_RESTART: begin
        mode_field_next = 3'h0;
        if (rd_done && !critical) begin
          mode_next = SMC_NORMAL;
          mode_field_next = SMC_NORMAL;
        end
      end
      SMC_FAILSAFE: begin
        if (wake_s && !tsd_s) begin
          mode_next = SMC_RESTART;
        end
      end
      default: mode_next = SMC_INIT;
    endcase
    if (critical && mode_reg != SMC_FAILSAFE) begin
      mode_next = SMC_FAILSAFE;
    end
    if (mode_next == SMC_RESTART && mode_reg != SMC_RESTART) begin
      mode_field_next = 3'h0;
    end
  end
  // ==========================================================
  // bus next values
  always_comb begin
    ack_next = req;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      case (avs_address)
        `SMC_MODE_CTRL_OFS: rdata_next = {28'h0, uv_reg, mode_field_reg};
        `SMC_HARDWARE_CONTROL_REGISTER_OFS: rdata_next = {30'h0, debug_reg, miss_sel_reg};
        `SMC_WATCHDOG_CONTROL_REGISTER_OFS: rdata_next = {31'h0, limit_reg};
        `SMC_STATUS_OFS: rdata_next = {24'h0, wd_run, fail_reg,
          wd_fail_reg, rst_cnt_reg, mode_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_reg <= SMC_INIT;
      mode_field_reg <= 3'h0;
      miss_sel_reg <= `SMC_HARDWARE_CONTROL_REGISTER_RST;
      limit_reg <= `SMC_WD_LIMIT_RST;
      debug_reg <= 1'b0;
      released_reg <= 1'b0;
      miss_cnt_reg <= 1'b0;
      rst_cnt_reg <= 2'h0;
      fail_reg <= 1'b0;
      wd_fail_reg <= 1'b0;
      uv_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      mode_reg <= mode_next;
      mode_field_reg <= mode_field_next;
      miss_sel_reg <= miss_sel_next;
      limit_reg <= limit_next;
      debug_reg <= debug_next;
      released_reg <= released_next;
      miss_cnt_reg <= miss_cnt_next;
      rst_cnt_reg <= rst_cnt_next;
      fail_reg <= fail_next;
      wd_fail_reg <= wd_fail_next;
      uv_reg <= uv_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
  // ==========================================================
  // outputs
  assign avs_waitrequest = !ack_reg;
  assign avs_readdata = rdata_reg;
  assign strap_pullup_en = mode_reg == SMC_INIT;
  assign strap_oe = mode_reg != SMC_INIT && fail_reg;
  assign strap_out = 1'b0;
  assign fail_outputs = fail_reg;
  assign reset_output_pin_n = released_reg && supply_ok_s
    && mode_reg != SMC_RESTART && mode_reg != SMC_SLEEP;
  assign main_regulator_en = mode_reg != SMC_SLEEP
    && mode_reg != SMC_FAILSAFE;
  assign main_supply_undervoltage_flag = uv_reg;
  assign operating_mode = mode_reg;
endmodule

// ==== smc_params.svh ====
// offsets, field positions, reset values and timing counts for the mode controller
// assumes a 200 MHz core clock and a 32-bit avalon-mm register port
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses)
`define SMC_MODE_CTRL_OFS 4'h0
`define SMC_HARDWARE_CONTROL_REGISTER_OFS 4'h4
`define SMC_WATCHDOG_CONTROL_REGISTER_OFS 4'h8
`define SMC_STATUS_OFS 4'hc
// ==========================================================
// field positions
`define SMC_HW_MISS_SEL_BIT 0
`define SMC_WD_LIMIT_BIT 0
`define SMC_WD_TRIG_BIT 1
`define SMC_MODE_SOFT_RST 3'h7
// ==========================================================
// reset values
`define SMC_HARDWARE_CONTROL_REGISTER_RST 1'b0
`define SMC_WD_LIMIT_RST 1'b0
// ==========================================================
// timing: clock period, reset delay and long open window
`define SMC_CLK_PS 5000
`define SMC_RESET_DELAY_US 10
`define SMC_LONG_WINDOW_MS 200
`define SMC_RESET_DELAY_CYC (`SMC_RESET_DELAY_US * 1000000 / `SMC_CLK_PS)
`define SMC_LONG_WINDOW_CYC (`SMC_LONG_WINDOW_MS * 1000000 / (`SMC_CLK_PS / 1000))
`define SMC_RESET_LIMIT 2'h3
`endif

// ==== smc_pkg.sv ====
// types shared by the mode controller files
// assumes smc_params.svh supplies the numeric constants
package smc_pkg;
  // ==========================================================
  // operating modes
  typedef enum logic [2:0] {
    SMC_INIT = 3'b000,
    SMC_NORMAL = 3'b001,
    SMC_STOP = 3'b010,
    SMC_SLEEP = 3'b011,
    SMC_RESTART = 3'b100,
    SMC_FAILSAFE = 3'b101
  } smc_mode_t;
endpackage

// ==== smc_sync.sv ====
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to core_clk
`timescale 1ns/10ps
module smc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  // ==========================================================
  // next values
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end
  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  assign pin_sync = sync_reg;
endmodule

// ==== smc_timer.sv ====
// loadable down counter that pulses when it runs out
// assumes start and hold come from logic on core_clk
`timescale 1ns/10ps
module smc_timer #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] COUNT = '1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic stop,
  input wire logic hold,
  output logic running,
  output logic expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic run_reg;
  logic run_next;
  logic exp_reg;
  logic exp_next;
  // ==========================================================
  // next values
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (start) begin
      cnt_next = COUNT;
      run_next = 1'b1;
    end else if (stop) begin
      run_next = 1'b0;
    end else if (run_reg && !hold) begin
      if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        run_next = 1'b0;
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end
  assign running = run_reg;
  assign expired = exp_reg;
endmodule

// ==== smc_host_model.sv ====
// host controller model: avalon-mm master for the mode controller
// assumes requests are placed only after core_clk rising edges
`timescale 1ns/10ps
module smc_host_model (
  input wire logic core_clk,
  input wire logic reset_output_pin_n,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // ==========================================================
  // one word transfer after an idle gap, held until accepted
  task automatic xfer(input logic w, input logic [3:0] a,
      input logic [31:0] d, input int gap, output logic [31:0] q);
    repeat (gap + 1) @(posedge core_clk);
    while (reset_output_pin_n !== 1'b1) @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
    avs_byteenable <= 4'h0;
  endtask
endmodule

// ==== smc_mode_ctrl_sva.sv ====
// port checker for the mode controller
// assumes one core_clk domain and sys_rst synchronous active high
`timescale 1ns/10ps
module smc_mode_ctrl_chk #(
  parameter int unsigned RESET_DELAY_CYC = 20
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic main_supply_ok,
  input wire logic thermal_shutdown_level_two,
  input wire logic main_supply_short,
  input wire logic reset_output_pin_n,
  input wire logic main_regulator_en,
  input wire logic strap_pullup_en,
  input wire logic strap_oe,
  input smc_pkg::smc_mode_t operating_mode
);
  import smc_pkg::*;
  localparam int RD_MAX = RESET_DELAY_CYC + 12;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // assertions and cover points
  AST_BUS_ANSWER:
    assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("bus request not answered");
  AST_RO_RELEASE:
    assert property ($rose(reset_output_pin_n) |->
      $past(main_supply_ok, RESET_DELAY_CYC)) else $error("early release");
  AST_RO_HELD:
    assert property (!main_supply_ok [*4] |-> !reset_output_pin_n)
      else $error("reset released without supply");
  AST_RESTART_RO:
    assert property ((operating_mode == SMC_RESTART) [*2] |->
      !reset_output_pin_n) else $error("no reset in restart");
  AST_RESTART_EXIT:
    assert property ($rose(operating_mode == SMC_RESTART) && main_supply_ok
      && !thermal_shutdown_level_two && !main_supply_short |->
      ##[1:RD_MAX] operating_mode != SMC_RESTART) else $error("restart stuck");
  AST_FAILSAFE_IN:
    assert property ((thermal_shutdown_level_two || main_supply_short) &&
      operating_mode != SMC_INIT |-> ##[1:6] operating_mode == SMC_FAILSAFE)
      else $error("no fail-safe entry");
  AST_FAILSAFE_HOLD:
    assert property (thermal_shutdown_level_two [*3] ##0
      operating_mode == SMC_FAILSAFE |=> operating_mode == SMC_FAILSAFE)
      else $error("fail-safe left while hot");
  AST_REG_OFF:
    assert property ((operating_mode inside {SMC_SLEEP, SMC_FAILSAFE}) [*2]
      |-> !main_regulator_en) else $error("regulator on");
  AST_STOP_REG_ON:
    assert property ((operating_mode == SMC_STOP) [*2] |-> main_regulator_en)
      else $error("regulator off in stop");
  AST_INIT_PULLUP:
    assert property ((operating_mode == SMC_INIT) [*2] |->
      strap_pullup_en && !strap_oe) else $error("strap not an input");
  AST_INIT_HOLD:
    assert property ((!avs_read && !avs_write) [*3] ##0
      operating_mode == SMC_INIT && !thermal_shutdown_level_two &&
      !main_supply_short |=> operating_mode == SMC_INIT)
      else $error("init left without command");
  CV_RESTART: cover property ($rose(operating_mode == SMC_RESTART));
  CV_FAILSAFE: cover property ($rose(operating_mode == SMC_FAILSAFE));
  CV_SLEEP: cover property ($rose(operating_mode == SMC_SLEEP));
endmodule
bind smc_mode_ctrl smc_mode_ctrl_chk #(
  .RESET_DELAY_CYC(RESET_DELAY_CYC)
) chk_i (.core_clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .main_supply_ok, .thermal_shutdown_level_two, .main_supply_short,
  .reset_output_pin_n, .main_regulator_en, .strap_pullup_en, .strap_oe,
  .operating_mode);

// ==== system_mode_controller_test.sv ====
// self-checking bench for the mode controller
// assumes smc_host_model as bus master and the bound port checker
`timescale 1ns/10ps
`include "smc_params.svh"
module system_mode_controller_test;
  import smc_pkg::*;
  localparam int RD = 20;
  localparam int LW = 200;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic main_supply_ok = 1'b0;
  logic supply_uv_timeout_ok = 1'b0;
  logic thermal_shutdown_level_two = 1'b0;
  logic main_supply_short = 1'b0;
  logic wake_event = 1'b0;
  logic strap_drv = 1'b1;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic strap_out, strap_oe, strap_pullup_en, fail_outputs;
  logic reset_output_pin_n, main_regulator_en;
  logic main_supply_undervoltage_flag;
  smc_mode_t operating_mode;
  logic [31:0] lfsr = 32'h41f5fd20;
  int err_count = 0;
  int comparisons = 0;
  int t;
  wire logic strap_pin = strap_oe ? strap_out : strap_drv;
  smc_mode_ctrl #(.RESET_DELAY_CYC(RD), .LONG_WINDOW_CYC(LW)) uut (
    .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .main_supply_ok, .supply_uv_timeout_ok, .thermal_shutdown_level_two,
    .main_supply_short, .wake_event, .strap_in(strap_pin), .strap_out,
    .strap_oe, .strap_pullup_en, .fail_outputs, .reset_output_pin_n,
    .main_regulator_en, .main_supply_undervoltage_flag, .operating_mode);
  smc_host_model host (.core_clk, .reset_output_pin_n, .avs_waitrequest,
    .avs_readdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable);
  always #2.5 core_clk = ~core_clk;
  // ==========================================================
  // expectations and helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic reg_on(input smc_mode_t m);
    return !(m inside {SMC_SLEEP, SMC_FAILSAFE});
  endfunction
  function automatic int miss_n(input int sel);
    return (sel != 0) ? 1 : 2;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    lfsr = nxt(lfsr);
    host.xfer(w, a, d, int'(lfsr[1:0]), q);
  endtask
  task automatic wait_mode(input smc_mode_t m, input int lim);
    t = 0;
    while (operating_mode !== m && t < lim) begin
      @(posedge core_clk);
      t++;
    end
    chk("mode", operating_mode, m);
  endtask
  task automatic wait_ro;
    t = 0;
    while (reset_output_pin_n !== 1'b1 && t < 200) begin
      @(posedge core_clk);
      t++;
    end
    chk("ro", reset_output_pin_n, 1'b1);
  endtask
  task automatic wake;
    wake_event <= 1'b1;
    cyc(4);
    wake_event <= 1'b0;
    cyc(4);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    chk("mode", operating_mode, SMC_INIT);
    cyc(20);
    chk("ro", reset_output_pin_n, 1'b0);
    chk("fail_uv", {fail_outputs, main_supply_undervoltage_flag}, 2'b00);
    main_supply_ok <= 1'b1;
    supply_uv_timeout_ok <= 1'b1;
    wait_ro;
    chk("release", t >= RD && t <= RD + 10, 1'b1);
    chk("pullup", strap_pullup_en, 1'b1);
    wake;
    chk("mode", operating_mode, SMC_INIT);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    wait_mode(SMC_NORMAL, 4);
    bus(1'b0, `SMC_HARDWARE_CONTROL_REGISTER_OFS, 32'h0);
    chk("hardware_control_register", q[1:0], 2'b00);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, `SMC_HARDWARE_CONTROL_REGISTER_OFS, 32'(s));
      bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, 32'h2);
      wait_mode(SMC_RESTART, 3 * LW);
      chk("miss_at", t / LW, miss_n(s));
      chk("fail_ro", {fail_outputs, strap_oe, reset_output_pin_n},
        3'b110);
      wait_mode(SMC_NORMAL, RD + 10);
      bus(1'b0, `SMC_MODE_CTRL_OFS, 32'h0);
      chk("field", q[2:0], SMC_NORMAL);
    end
    repeat (6) begin
      lfsr = nxt(lfsr);
      cyc(int'(lfsr[6:0]) + 40);
      bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, {lfsr[31:2], 2'b10});
      chk("kept", operating_mode, SMC_NORMAL);
    end
    bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, 32'h1);
    repeat (3) begin
      wait_mode(SMC_RESTART, LW + 20);
      wait_mode(SMC_NORMAL, RD + 10);
    end
    cyc(LW + 40);
    chk("limit", {operating_mode, reset_output_pin_n}, {SMC_NORMAL, 1'b1});
    bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, 32'h0);
    wait_mode(SMC_RESTART, LW + 20);
    wait_mode(SMC_NORMAL, RD + 10);
    bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, 32'h2);
    bus(1'b1, `SMC_MODE_CTRL_OFS, 32'h2);
    wait_mode(SMC_STOP, 4);
    cyc(2);
    chk("reg", main_regulator_en, reg_on(SMC_STOP));
    bus(1'b1, `SMC_MODE_CTRL_OFS, 32'h3);
    wait_mode(SMC_RESTART, 4);
    wait_mode(SMC_NORMAL, RD + 10);
    bus(1'b1, `SMC_MODE_CTRL_OFS, 32'h3);
    wait_mode(SMC_SLEEP, 4);
    cyc(2);
    chk("reg", main_regulator_en, reg_on(SMC_SLEEP));
    wake;
    wait_mode(SMC_NORMAL, RD + 10);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `SMC_WATCHDOG_CONTROL_REGISTER_OFS, 32'h2);
      {main_supply_short, thermal_shutdown_level_two} <= 2'(i + 1);
      wait_mode(SMC_FAILSAFE, 6);
      cyc(2);
      chk("reg", main_regulator_en, reg_on(SMC_FAILSAFE));
      if (i == 0) begin
        wake;
        chk("hot", operating_mode, SMC_FAILSAFE);
      end
      {main_supply_short, thermal_shutdown_level_two} <= 2'b00;
      cyc(6);
      chk("wait", operating_mode, SMC_FAILSAFE);
      wake;
      wait_mode(SMC_NORMAL, RD + 10);
    end
    main_supply_ok <= 1'b0;
    wait_mode(SMC_RESTART, 6);
    chk("ro_low", reset_output_pin_n, 1'b0);
    main_supply_ok <= 1'b1;
    wait_mode(SMC_NORMAL, RD + 10);
    bus(1'b0, `SMC_MODE_CTRL_OFS, 32'h0);
    chk("uv", {q[3], main_supply_undervoltage_flag}, 2'b11);
    bus(1'b1, `SMC_MODE_CTRL_OFS, 32'h9);
    bus(1'b0, `SMC_MODE_CTRL_OFS, 32'h0);
    chk("uv_clr", q[3:0], 4'h1);
    strap_drv <= 1'b0;
    bus(1'b1, `SMC_MODE_CTRL_OFS, {29'h0, `SMC_MODE_SOFT_RST});
    wait_mode(SMC_INIT, 4);
    wait_ro;
    bus(1'b0, `SMC_HARDWARE_CONTROL_REGISTER_OFS, 32'h0);
    chk("debug", q[1], 1'b1);
    wait_mode(SMC_NORMAL, 4);
    cyc(2 * LW + 40);
    chk("dev", {operating_mode, reset_output_pin_n}, {SMC_NORMAL, 1'b1});
    bus(1'b1, `SMC_MODE_CTRL_OFS, 32'h2);
    wait_mode(SMC_STOP, 4);
    end_sim;
  end
  initial begin
    cyc(20000);
    err_count++;
    end_sim;
  end
endmodule
